// >>> src/reset_supervisor_pkg.sv
package reset_supervisor_pkg;
  localparam logic [7:0] KEY_DISABLE = 8'h55;
  localparam logic [7:0] KEY_RESET = 8'h55;
  localparam logic [23:0] WDOG_RESET = 24'h000000;
  localparam logic [15:0] RELOAD_LOW = 16'h0000;
  localparam logic [15:0] RESET_VECTOR = 16'h0000;
  localparam logic [11:0] OFS_KEY = 12'h000;
  localparam logic [11:0] OFS_RELOAD = 12'h004;
  localparam logic [11:0] OFS_STATUS = 12'h008;
  localparam logic [11:0] OFS_CONTROL = 12'h00c;
  localparam int STATUS_POWER_UP = 0;
  localparam int STATUS_WDOG_EN = 1;
  localparam int STATUS_CAUSE_LSB = 4;
  localparam int CTRL_CLEAR_POWER_UP = 0;
  localparam int CTRL_LOGIC_POLARITY = 1;
  localparam int CLK_PERIOD_NS = 100;
  localparam int ACTIVE_HOLD_NS = 1000;
  localparam int ACTIVE_HOLD_CYCLES = (ACTIVE_HOLD_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam logic [2:0] MACH_CYCLE_BASE = 3'h4;
  typedef struct packed {
    logic pinReq;
    logic supplyLow;
    logic debugReq;
    logic wdogTimeout;
  } reset_src_s;
  typedef struct packed {
    logic idleMode;
    logic powerDownMode;
    logic memTransfer;
    logic [2:0] busWaitClocks;
    logic stall;
  } core_state_s;
endpackage : reset_supervisor_pkg

// >>> src/reset_supervisor_watchdog.sv
// The address map and register access over APB were left to the implementer.
`timescale 1ns/100ps
module reset_supervisor_watchdog
  import reset_supervisor_pkg::*;
(
  input wire logic clk,
  input wire logic rst_n,
  input wire logic resetPin_n,
  input wire logic supplyLow,
  input wire logic debugResetReq,
  input wire logic idleMode,
  input wire logic powerDownMode,
  input wire logic memTransfer,
  input wire logic [2:0] busWaitClocks,
  input wire logic stall,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  output logic coreReset,
  output logic logicReset_n,
  output logic logicResetOut,
  output logic [15:0] resetVector
);
  // synchronised inputs
  logic pinS1_r, pinS2_r, lowS1_r, lowS2_r, dbgS1_r, dbgS2_r;
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      pinS1_r <= 1'b1;
      pinS2_r <= 1'b1;
      lowS1_r <= 1'b0;
      lowS2_r <= 1'b0;
      dbgS1_r <= 1'b0;
      dbgS2_r <= 1'b0;
    end else begin
      pinS1_r <= resetPin_n;
      pinS2_r <= pinS1_r;
      lowS1_r <= supplyLow;
      lowS2_r <= lowS1_r;
      dbgS1_r <= debugResetReq;
      dbgS2_r <= dbgS1_r;
    end
  end

  reset_src_s src;
  logic [3:0] holdCnt_r;
  logic wdogTimeout_r;
  logic lowHold;
  assign lowHold = (holdCnt_r != 4'h0);
  // supply detector not gated by any mode or register
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      holdCnt_r <= 4'h0;
    end else if (lowS2_r) begin
      holdCnt_r <= 4'(ACTIVE_HOLD_CYCLES);
    end else if (lowHold) begin
      holdCnt_r <= holdCnt_r - 4'h1;
    end
  end

  always_comb begin
    src.pinReq = !pinS2_r;
    src.supplyLow = lowS2_r || lowHold;
    src.debugReq = dbgS2_r;
    src.wdogTimeout = wdogTimeout_r;
  end

  logic anyReset;
  assign anyReset = |src;
  logic [7:0] key_r;
  logic [23:0] count_r;
  logic [2:0] phase_r;
  logic powerUp_r, polarity_r;
  logic [3:0] cause_r;
  logic wdogEn, asleep, machTick;
  logic [2:0] machLen;
  assign wdogEn = (key_r != KEY_DISABLE);
  assign asleep = idleMode || powerDownMode;
  assign machLen = (memTransfer && busWaitClocks > MACH_CYCLE_BASE) ?
                   busWaitClocks : MACH_CYCLE_BASE;
  assign machTick = !stall && (phase_r >= machLen - 3'h1);

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      coreReset <= 1'b1;
      logicReset_n <= 1'b0;
      resetVector <= RESET_VECTOR;
    end else begin
      coreReset <= anyReset;
      logicReset_n <= !anyReset;
      resetVector <= RESET_VECTOR;
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      logicResetOut <= 1'b0;
    end else begin
      logicResetOut <= polarity_r ? anyReset : !anyReset;
    end
  end

  logic wrAcc, rdAcc, mapped;
  assign wrAcc = psel && penable && pwrite;
  assign rdAcc = psel && penable && !pwrite;
  assign mapped = paddr == OFS_KEY || paddr == OFS_RELOAD ||
                  paddr == OFS_STATUS || paddr == OFS_CONTROL;

  logic [2:0] phaseNxt;
  always_comb begin
    phaseNxt = phase_r;
    if (!wdogEn || asleep) phaseNxt = 3'h0;
    else if (machTick) phaseNxt = 3'h0;
    else if (phase_r != 3'h7) phaseNxt = phase_r + 3'h1;
  end

  logic overflow;
  assign overflow = wdogEn && !asleep && machTick && (count_r == 24'hffffff);

  always_ff @(posedge clk) begin
    if (!rst_n || anyReset) begin
      key_r <= KEY_RESET;
      count_r <= WDOG_RESET;
      phase_r <= 3'h0;
      // the request has been captured by coreReset; dropping it here avoids a reset lockup
      wdogTimeout_r <= 1'b0;
    end else begin
      phase_r <= phaseNxt;
      wdogTimeout_r <= 1'b0;
      if (overflow) begin
        wdogTimeout_r <= 1'b1;
        key_r <= KEY_DISABLE;
        count_r <= WDOG_RESET;
      end else begin
        if (wrAcc && paddr == OFS_KEY) key_r <= pwdata[7:0];
        if (wrAcc && paddr == OFS_RELOAD) begin
          count_r <= {pwdata[7:0], RELOAD_LOW};
        end else if (wdogEn && !asleep && machTick) begin
          count_r <= count_r + 24'h000001;
        end
      end
    end
  end

  // power-up flag: set wins over clear
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      powerUp_r <= 1'b0;
      polarity_r <= 1'b0;
      cause_r <= 4'h0;
    end else begin
      if (src.supplyLow) powerUp_r <= 1'b1;
      else if (wrAcc && paddr == OFS_CONTROL && pwdata[CTRL_CLEAR_POWER_UP]) powerUp_r <= 1'b0;
      if (wrAcc && paddr == OFS_CONTROL) polarity_r <= pwdata[CTRL_LOGIC_POLARITY];
      if (anyReset) cause_r <= src;
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      prdata <= 32'h00000000;
      pready <= 1'b0;
      pslverr <= 1'b0;
    end else begin
      pready <= psel && !penable;
      pslverr <= psel && !penable && !mapped;
      prdata <= 32'h00000000;
      if (psel && !penable && !pwrite) begin
        if (paddr == OFS_STATUS) begin
          prdata[STATUS_POWER_UP] <= powerUp_r;
          prdata[STATUS_WDOG_EN] <= wdogEn;
          prdata[STATUS_CAUSE_LSB +: 4] <= cause_r;
        end else if (paddr == OFS_CONTROL) begin
          prdata[CTRL_LOGIC_POLARITY] <= polarity_r;
        end
      end
    end
  end

  property p_timeout_reset;
    @(posedge clk) disable iff (!rst_n) wdogTimeout_r |=> coreReset && !logicReset_n;
  endproperty
  a_timeout_reset: assert property (p_timeout_reset) else $error("timeout without reset");
  a_pin_reset: assert property (@(posedge clk) disable iff (!rst_n)
    !pinS2_r |=> coreReset) else $error("pin reset missed");
  a_logic_pair: assert property (@(posedge clk) disable iff (!rst_n)
    coreReset == !logicReset_n) else $error("resets disagree");
  a_key_restore: assert property (@(posedge clk) disable iff (!rst_n)
    overflow |=> key_r == KEY_DISABLE) else $error("key not restored");
  a_reload_load: assert property (@(posedge clk) disable iff (!rst_n)
    wrAcc && paddr == OFS_RELOAD && !anyReset && !overflow
    |=> count_r == {$past(pwdata[7:0]), RELOAD_LOW}) else $error("reload wrong");
  a_sleep_hold: assert property (@(posedge clk) disable iff (!rst_n)
    asleep && !anyReset && !(wrAcc && paddr == OFS_RELOAD) |=> $stable(count_r))
    else $error("counted asleep");
  a_power_flag: assert property (@(posedge clk) disable iff (!rst_n)
    src.supplyLow |=> powerUp_r) else $error("power flag not set");
  a_supply_hold: assert property (@(posedge clk) disable iff (!rst_n)
    $fell(lowS2_r) |-> ##1 coreReset[*8]) else $error("supply hold short");
  a_key_default: assert property (@(posedge clk) disable iff (!rst_n)
    anyReset |=> key_r == KEY_RESET && count_r == WDOG_RESET)
    else $error("reset defaults wrong");
  a_vector_zero: assert property (@(posedge clk) disable iff (!rst_n)
    $fell(coreReset) |-> resetVector == RESET_VECTOR) else $error("vector wrong");
  a_timeout_pulse: assert property (@(posedge clk) disable iff (!rst_n)
    wdogTimeout_r |=> !wdogTimeout_r) else $error("timeout stuck");
  a_debug_reset: assert property (@(posedge clk) disable iff (!rst_n)
    dbgS2_r |=> coreReset) else $error("debug reset missed");
  a_tick_gate: assert property (@(posedge clk) disable iff (!rst_n)
    !anyReset && !(wrAcc && paddr == OFS_RELOAD) && !machTick |=> $stable(count_r))
    else $error("count moved off tick");
  a_count_step: assert property (@(posedge clk) disable iff (!rst_n)
    wdogEn && !asleep && machTick && !anyReset && !overflow && !(wrAcc && paddr == OFS_RELOAD)
    |=> count_r == $past(count_r) + 24'h000001) else $error("count step wrong");
  a_disabled_hold: assert property (@(posedge clk) disable iff (!rst_n)
    !wdogEn && !anyReset && !(wrAcc && paddr == OFS_RELOAD) |=> $stable(count_r))
    else $error("disabled watchdog counted");
endmodule : reset_supervisor_watchdog

// >>> verif/apb_firmware.sv
`timescale 1ns/100ps
module apb_firmware (
  input wire logic clk,
  input wire logic pready,
  input wire logic [31:0] prdata,
  input wire logic pslverr,
  output logic psel,
  output logic penable,
  output logic pwrite,
  output logic [11:0] paddr,
  output logic [31:0] pwdata
);
  int hangs = 0;
  initial begin
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 12'h000;
    pwdata = 32'h0;
  end
  // request held until pready is seen high at a rising edge, or for at most 16 edges
  task automatic xfer(input logic w, input logic [11:0] a, input logic [31:0] d,
                      output logic [31:0] r, output logic e);
    int i;
    @(posedge clk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    for (i = 0; i < 16; i++) begin
      @(posedge clk);
      if (pready === 1'b1) break;
    end
    if (i == 16) hangs++;
    r = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : xfer
  task automatic set_key(input logic [7:0] k, output logic e);
    logic [31:0] r;
    xfer(1'b1, 12'h000, {24'h0, k}, r, e);
  endtask : set_key
  task automatic service(input logic [7:0] v, output logic e);
    logic [31:0] r;
    xfer(1'b1, 12'h004, {24'h0, v}, r, e);
  endtask : service
endmodule : apb_firmware

// >>> verif/tb_reset_supervisor_watchdog.sv
`timescale 1ns/100ps
`define CHK(n, e, a) begin checks_done++; if ((a) !== (e)) begin fails++; \
  $display("ERROR %s expected %0h seen %0h", n, e, a); end end
module tb_reset_supervisor_watchdog;
  import reset_supervisor_pkg::*;
  logic clk = 0, rst_n = 0, resetPin_n = 1, supplyLow = 0, debugResetReq = 0;
  logic idleMode = 0, powerDownMode = 0, memTransfer = 0, stall = 0, err;
  logic [2:0] busWaitClocks = 3'h0;
  logic psel, penable, pwrite, pready, pslverr, coreReset, logicReset_n, logicResetOut;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, rd;
  logic [15:0] resetVector;
  logic [7:0] key;
  int fails = 0, checks_done = 0, hiCnt = 0;
  always #50 clk = ~clk;
  always @(posedge clk) if (coreReset === 1'b1) hiCnt <= hiCnt + 1;
  always @(posedge clk) if (rst_n) `CHK("logicReset_n", ~coreReset, logicReset_n)
  reset_supervisor_watchdog u_dut (.clk, .rst_n, .resetPin_n, .supplyLow, .debugResetReq,
    .idleMode, .powerDownMode, .memTransfer, .busWaitClocks, .stall, .psel, .penable,
    .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr, .coreReset, .logicReset_n,
    .logicResetOut, .resetVector);
  apb_firmware u_fw (.clk, .pready, .prdata, .pslverr, .psel, .penable, .pwrite, .paddr,
    .pwdata);
  task automatic end_sim;
    fails += u_fw.hangs;
    $display("checks %0d fails %0d", checks_done, fails);
    if (fails == 0 && checks_done > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask : end_sim
  task automatic wait_low;
    int i;
    for (i = 0; i < 400 && coreReset !== 1'b0; i++) @(posedge clk);
    if (i == 400) begin
      fails++;
      end_sim();
    end
  endtask : wait_low
  // kind 0 pin, 1 low supply, 2 debug; source held n cycles
  task automatic pulse(input int kind, input int n);
    hiCnt = 0;
    @(posedge clk);
    resetPin_n <= kind != 0;
    supplyLow <= kind == 1;
    debugResetReq <= kind == 2;
    repeat (n) @(posedge clk);
    resetPin_n <= 1'b1;
    supplyLow <= 1'b0;
    debugResetReq <= 1'b0;
    repeat (4) @(posedge clk);
    wait_low();
  endtask : pulse
  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    u_fw.xfer(1'b1, a, d, rd, err);
  endtask : wr
  task automatic rdchk(input string n, input logic [11:0] a, input logic [31:0] m,
                       input logic [31:0] e);
    u_fw.xfer(1'b0, a, 32'h0, rd, err);
    `CHK(n, e, rd & m)
  endtask : rdchk
  initial begin
    void'($urandom(96));
    repeat (6) @(posedge clk);
    `CHK("coreReset", 1'b1, coreReset)
    rst_n <= 1'b1;
    wait_low();
    `CHK("resetVector", RESET_VECTOR, resetVector)
    rdchk("wdogEn", OFS_STATUS, 32'h2, 32'h0);
    $display("test reset done");
    for (int i = 0; i < 8; i++) begin
      key = (i == 0) ? 8'h55 : (i == 1) ? 8'h54 : (i == 7) ? 8'haa : 8'($urandom);
      memTransfer <= 1'($urandom);
      busWaitClocks <= 3'($urandom);
      stall <= 1'($urandom);
      u_fw.set_key(key, err);
      u_fw.service(8'($urandom), err);
      rdchk("wdogEn", OFS_STATUS, 32'h2, {30'h0, key != 8'h55, 1'b0});
    end
    $display("test key done");
    wr(OFS_CONTROL, 32'h2);
    repeat (2) @(posedge clk);
    `CHK("logicResetOut", 1'b0, logicResetOut)
    wr(OFS_CONTROL, 32'h0);
    repeat (2) @(posedge clk);
    `CHK("logicResetOut", 1'b1, logicResetOut)
    pulse(0, 8);
    `CHK("pin reset length", 8, hiCnt)
    rdchk("wdogEn", OFS_STATUS, 32'h2, 32'h0);
    $display("test pin done");
    powerDownMode <= 1'b1;
    pulse(1, 5);
    powerDownMode <= 1'b0;
    `CHK("supply reset length", 5 + ACTIVE_HOLD_CYCLES, hiCnt)
    rdchk("powerUp", OFS_STATUS, 32'h1, 32'h1);
    wr(OFS_CONTROL, 32'h1);
    rdchk("powerUp", OFS_STATUS, 32'h1, 32'h0);
    $display("test supply done");
    u_fw.set_key(8'haa, err);
    idleMode <= 1'b1;
    pulse(2, 4);
    idleMode <= 1'b0;
    `CHK("debug reset", 1'b1, hiCnt > 0)
    rdchk("wdogEn", OFS_STATUS, 32'h2, 32'h0);
    u_fw.xfer(1'b0, 12'h010, 32'h0, rd, err);
    `CHK("pslverr", 1'b1, err)
    $display("test debug done");
    end_sim();
  end
endmodule : tb_reset_supervisor_watchdog
